// ---- hw/conv_regs_pkg.sv ----
// Package: offsets, field positions and reset values of the converter control
// and interrupt registers.
// Assumes a 16-bit register word and a 5-bit register address from the serial port.
package conv_regs_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_SECOND_CHANNEL_CONVERTER_CONTROL = 5'h07;
    localparam logic [ADDR_W-1:0] ADDR_SECOND_AUX_CONVERTER_CONTROL = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_CONTROL_STATUS = 5'h09;

    ////////////////////////////////////////////////////////////////////////////
    // Second-channel converter control fields
    localparam int CONV_SLEEP_BIT = 15;
    localparam int CONV_POWER_DOWN_BIT = 14;
    localparam int CONV_GAIN_LSB = 0;
    localparam int GAIN_W = 10;
    localparam logic [DATA_W-1:0] CONV_WRITE_MASK = 16'hC3FF;
    localparam logic [DATA_W-1:0] CONV_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Second auxiliary converter control fields
    localparam int AUX_SIGN_BIT = 15;
    localparam int AUX_SINK_BIT = 14;
    localparam int AUX_POWER_DOWN_BIT = 13;
    localparam int AUX_DATA_LSB = 0;
    localparam logic [DATA_W-1:0] AUX_WRITE_MASK = 16'hE3FF;
    localparam logic [DATA_W-1:0] AUX_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt control and status fields
    localparam int IRQ_CLEAR_LOCK_BIT = 12;
    localparam int IRQ_SYNC_LOST_BIT = 11;
    localparam int IRQ_SYNC_LIVE_BIT = 10;
    localparam int IRQ_DATA_ERR_BIT = 7;
    localparam int IRQ_SYNC_ERR_BIT = 6;
    localparam int IRQ_DATA_TYPE_BIT = 5;
    localparam int IRQ_SYNC_TYPE_BIT = 4;
    localparam int IRQ_PLL_LOCK_BIT = 3;
    localparam int IRQ_DATA_EN_BIT = 1;
    localparam int IRQ_SYNC_EN_BIT = 0;
    localparam logic IRQ_EN_RESET = 1'b0;
    localparam logic CLEAR_LOCK_RESET = 1'b0;

endpackage

// ---- hw/ctrl_word_reg.sv ----
// Holds one writable control word; bits outside the write mask stay at reset.
// Assumes write strobe, address and data synchronous to clk.
`timescale 1ns/1ns
`default_nettype none

module ctrl_word_reg #(
    parameter int WIDTH = 16,
    parameter int AW = 5,
    parameter logic [AW-1:0] ADDR = '0,
    parameter logic [WIDTH-1:0] WRITE_MASK = '1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Register write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // Stored word
    output logic [WIDTH-1:0] value
);

    // Refuse widths the word logic cannot hold
    if (WIDTH < 1 || AW < 1) begin : gBadWidth
        $error("ctrl_word_reg: bad width");
    end

    typedef struct packed {
        logic [WIDTH-1:0] word;
    } state_t;

    state_t state;
    state_t next_state;

    always_comb begin
        next_state = state;
        if (wrEn && wrAddr == ADDR) begin
            // Reserved bits keep their reset value
            next_state.word = (wrData & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state <= '{word: RESET_VALUE};
        end else begin
            state <= next_state;
        end
    end

    assign value = state.word;

endmodule

`default_nettype wire

// ---- hw/timing_err_flag.sv ----
// Sticky timing error flag with its error type bit.
// Assumes one-cycle error pulses from a setup/hold checker.
`timescale 1ns/1ns
`default_nettype none

module timing_err_flag (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Checker side
    input wire logic enable,
    input wire logic errPulse,
    input wire logic errIsSetup,
    // Status
    output logic flag,
    output logic isSetup
);

    typedef struct packed {
        logic flag;
        logic isSetup;
    } state_t;

    state_t state;
    state_t next_state;

    always_comb begin
        next_state = state;
        if (!enable) begin
            // Masked errors neither set nor hold the flag
            next_state.flag = 1'b0;
        end else if (errPulse) begin
            next_state.flag = 1'b1;
            next_state.isSetup = errIsSetup;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state <= '{flag: 1'b0, isSetup: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign flag = state.flag;
    assign isSetup = state.isSetup;

endmodule

`default_nettype wire

// ---- hw/dac_ctrl_irq_status_regs.sv ----
// Second-channel converter control, second auxiliary converter control and the
// interrupt control/status register, with the active-low interrupt pin.
// Assumes the serial port controller presents decoded word accesses on clk.
//
// Functional notes
// - Sleep bit 15 set puts second-channel converter to low power; clear keeps active.
// - Power-down bit 14 set makes second-channel converter inactive; default active.
// - Ten-bit gain value in bits 9:0 drives second-channel converter gain.
// - Aux sign bit 15 picks polarity and active pin; 0 positive pin.
// - Aux direction bit 14: 0 sources current, 1 sinks current.
// - Aux power-down bit 13 set makes aux converter inactive; default active.
// - Ten-bit aux data in bits 9:0 drives aux converter gain adjust.
// - Interrupt bits 11:10 and 7:3 come from logic; writes ignored.
// - Interrupt request shown by driving the interrupt pin low.
// - Interrupt bits 1:0 are enables, writable and readable.
// - Writing 1 to bit 12 clears latched sync-lost; bit stays until rewritten.
// - Sync-lost bit sets on lost sync and holds until cleared.
// - Live sync bit reads high while synchronized.
// - Data timing error flag reads 1 after a data port violation.
// - Sync timing error flag reads 1 after a sync receiver violation.
// - Data error type: 0 hold, 1 setup; valid with data flag.
// - Sync error type: 0 hold, 1 setup; valid with sync flag.
// - PLL lock bit reads 1 while the clock multiplier is locked.
// - Data enable 0 masks data errors from flag and pin.
// - Sync enable 0 masks sync errors from flag and pin.
`timescale 1ns/1ns
`default_nettype none

module dac_ctrl_irq_status_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Serial port register access
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [conv_regs_pkg::ADDR_W-1:0] regAddr,
    input wire logic [conv_regs_pkg::DATA_W-1:0] regWriteData,
    output logic [conv_regs_pkg::DATA_W-1:0] regReadData,
    output logic regReadValid,
    // Status sources
    input wire logic syncLocked,
    input wire logic pllLocked,
    input wire logic dataErrPulse,
    input wire logic dataErrIsSetup,
    input wire logic syncErrPulse,
    input wire logic syncErrIsSetup,
    // Second-channel converter controls
    output logic convSleep,
    output logic convPowerDown,
    output logic [conv_regs_pkg::GAIN_W-1:0] convGain,
    // Second auxiliary converter controls
    output logic auxNegative,
    output logic auxPosPinActive,
    output logic auxNegPinActive,
    output logic auxSink,
    output logic auxPowerDown,
    output logic [conv_regs_pkg::GAIN_W-1:0] auxData,
    // Interrupt pin
    output logic irq_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Control bits inside the register word
    if (conv_regs_pkg::CONV_SLEEP_BIT >= conv_regs_pkg::DATA_W) begin : gConvSleepPos
        $error("second-channel sleep bit outside the register word");
    end
    if (conv_regs_pkg::AUX_SIGN_BIT >= conv_regs_pkg::DATA_W) begin : gAuxSignPos
        $error("aux sign bit outside the register word");
    end
    if (conv_regs_pkg::IRQ_CLEAR_LOCK_BIT >= conv_regs_pkg::DATA_W) begin : gClearLockPos
        $error("clear-lock bit outside the register word");
    end

    // Value fields below the control bits
    if (conv_regs_pkg::CONV_GAIN_LSB + conv_regs_pkg::GAIN_W
            > conv_regs_pkg::CONV_POWER_DOWN_BIT) begin : gConvGainPos
        $error("second-channel gain field overlaps its control bits");
    end
    if (conv_regs_pkg::AUX_DATA_LSB + conv_regs_pkg::GAIN_W
            > conv_regs_pkg::AUX_POWER_DOWN_BIT) begin : gAuxDataPos
        $error("aux data field overlaps its control bits");
    end

    // Control bits writable through the masks
    if (!conv_regs_pkg::CONV_WRITE_MASK[conv_regs_pkg::CONV_SLEEP_BIT]) begin : gConvSleepWr
        $error("second-channel sleep bit not writable");
    end
    if (!conv_regs_pkg::CONV_WRITE_MASK[conv_regs_pkg::CONV_POWER_DOWN_BIT]) begin : gConvPdWr
        $error("second-channel power-down bit not writable");
    end
    if (!conv_regs_pkg::AUX_WRITE_MASK[conv_regs_pkg::AUX_SIGN_BIT]) begin : gAuxSignWr
        $error("aux sign bit not writable");
    end
    if (!conv_regs_pkg::AUX_WRITE_MASK[conv_regs_pkg::AUX_SINK_BIT]) begin : gAuxSinkWr
        $error("aux direction bit not writable");
    end
    if (!conv_regs_pkg::AUX_WRITE_MASK[conv_regs_pkg::AUX_POWER_DOWN_BIT]) begin : gAuxPdWr
        $error("aux power-down bit not writable");
    end

    // Reserved bits reset to zero
    if ((conv_regs_pkg::CONV_RESET & ~conv_regs_pkg::CONV_WRITE_MASK) != '0) begin : gConvRsv
        $error("second-channel reserved bits not zero at reset");
    end
    if ((conv_regs_pkg::AUX_RESET & ~conv_regs_pkg::AUX_WRITE_MASK) != '0) begin : gAuxRsv
        $error("aux reserved bits not zero at reset");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rstPipe;
    logic rstN;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end

    assign rstN = rstPipe[1];

    ////////////////////////////////////////////////////////////////////////////
    // Control words

    logic [conv_regs_pkg::DATA_W-1:0] convWord;
    logic [conv_regs_pkg::DATA_W-1:0] auxWord;

    ctrl_word_reg #(
        .WIDTH(conv_regs_pkg::DATA_W),
        .AW(conv_regs_pkg::ADDR_W),
        .ADDR(conv_regs_pkg::ADDR_SECOND_CHANNEL_CONVERTER_CONTROL),
        .WRITE_MASK(conv_regs_pkg::CONV_WRITE_MASK),
        .RESET_VALUE(conv_regs_pkg::CONV_RESET)
    ) uConvReg (
        .clk(clk),
        .rstN(rstN),
        .wrEn(regWrite),
        .wrAddr(regAddr),
        .wrData(regWriteData),
        .value(convWord)
    );

    ctrl_word_reg #(
        .WIDTH(conv_regs_pkg::DATA_W),
        .AW(conv_regs_pkg::ADDR_W),
        .ADDR(conv_regs_pkg::ADDR_SECOND_AUX_CONVERTER_CONTROL),
        .WRITE_MASK(conv_regs_pkg::AUX_WRITE_MASK),
        .RESET_VALUE(conv_regs_pkg::AUX_RESET)
    ) uAuxReg (
        .clk(clk),
        .rstN(rstN),
        .wrEn(regWrite),
        .wrAddr(regAddr),
        .wrData(regWriteData),
        .value(auxWord)
    );

    assign convSleep = convWord[conv_regs_pkg::CONV_SLEEP_BIT];
    assign convPowerDown = convWord[conv_regs_pkg::CONV_POWER_DOWN_BIT];
    assign convGain = convWord[conv_regs_pkg::CONV_GAIN_LSB +: conv_regs_pkg::GAIN_W];
    assign auxNegative = auxWord[conv_regs_pkg::AUX_SIGN_BIT];
    assign auxSink = auxWord[conv_regs_pkg::AUX_SINK_BIT];
    assign auxPowerDown = auxWord[conv_regs_pkg::AUX_POWER_DOWN_BIT];
    assign auxData = auxWord[conv_regs_pkg::AUX_DATA_LSB +: conv_regs_pkg::GAIN_W];

    ////////////////////////////////////////////////////////////////////////////
    // Timing error flags

    typedef struct packed {
        logic dataEn;
        logic syncEn;
        logic clearLock;
        logic syncLost;
        logic syncPrev;
        logic syncLive;
        logic pllLock;
        logic irqN;
        logic posPin;
        logic negPin;
        logic [conv_regs_pkg::DATA_W-1:0] readData;
        logic readValid;
    } state_t;

    state_t state;
    state_t next_state;

    logic dataFlag;
    logic dataIsSetup;
    logic syncFlag;
    logic syncIsSetup;

    timing_err_flag uDataErr (
        .clk(clk),
        .rstN(rstN),
        .enable(state.dataEn),
        .errPulse(dataErrPulse),
        .errIsSetup(dataErrIsSetup),
        .flag(dataFlag),
        .isSetup(dataIsSetup)
    );

    timing_err_flag uSyncErr (
        .clk(clk),
        .rstN(rstN),
        .enable(state.syncEn),
        .errPulse(syncErrPulse),
        .errIsSetup(syncErrIsSetup),
        .flag(syncFlag),
        .isSetup(syncIsSetup)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt register and read path

    logic [conv_regs_pkg::DATA_W-1:0] irqWord;

    always_comb begin
        irqWord = '0;
        irqWord[conv_regs_pkg::IRQ_CLEAR_LOCK_BIT] = state.clearLock;
        irqWord[conv_regs_pkg::IRQ_SYNC_LOST_BIT] = state.syncLost;
        irqWord[conv_regs_pkg::IRQ_SYNC_LIVE_BIT] = state.syncLive;
        irqWord[conv_regs_pkg::IRQ_DATA_ERR_BIT] = dataFlag;
        irqWord[conv_regs_pkg::IRQ_SYNC_ERR_BIT] = syncFlag;
        irqWord[conv_regs_pkg::IRQ_DATA_TYPE_BIT] = dataIsSetup;
        irqWord[conv_regs_pkg::IRQ_SYNC_TYPE_BIT] = syncIsSetup;
        irqWord[conv_regs_pkg::IRQ_PLL_LOCK_BIT] = state.pllLock;
        irqWord[conv_regs_pkg::IRQ_DATA_EN_BIT] = state.dataEn;
        irqWord[conv_regs_pkg::IRQ_SYNC_EN_BIT] = state.syncEn;
    end

    always_comb begin
        next_state = state;
        // Live status sampled from logic; software cannot write them
        next_state.syncLive = syncLocked;
        next_state.pllLock = pllLocked;
        next_state.syncPrev = syncLocked;
        if (regWrite && regAddr == conv_regs_pkg::ADDR_INTERRUPT_CONTROL_STATUS) begin
            next_state.dataEn = regWriteData[conv_regs_pkg::IRQ_DATA_EN_BIT];
            next_state.syncEn = regWriteData[conv_regs_pkg::IRQ_SYNC_EN_BIT];
            next_state.clearLock = regWriteData[conv_regs_pkg::IRQ_CLEAR_LOCK_BIT];
        end
        // Clear while control bit is 1, loss of sync wins
        if (state.clearLock) begin
            next_state.syncLost = 1'b0;
        end
        if (state.syncPrev && !syncLocked) begin
            next_state.syncLost = 1'b1;
        end
        // Pin low only for enabled, set flags
        next_state.irqN = !((dataFlag && state.dataEn) || (syncFlag && state.syncEn));
        next_state.posPin = !auxWord[conv_regs_pkg::AUX_SIGN_BIT];
        next_state.negPin = auxWord[conv_regs_pkg::AUX_SIGN_BIT];
        next_state.readValid = regRead;
        if (regRead) begin
            unique case (regAddr)
                conv_regs_pkg::ADDR_SECOND_CHANNEL_CONVERTER_CONTROL: begin
                    next_state.readData = convWord;
                end
                conv_regs_pkg::ADDR_SECOND_AUX_CONVERTER_CONTROL: begin
                    next_state.readData = auxWord;
                end
                conv_regs_pkg::ADDR_INTERRUPT_CONTROL_STATUS: begin
                    next_state.readData = irqWord;
                end
                default: begin
                    next_state.readData = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state <= '{
                dataEn: conv_regs_pkg::IRQ_EN_RESET,
                syncEn: conv_regs_pkg::IRQ_EN_RESET,
                clearLock: conv_regs_pkg::CLEAR_LOCK_RESET,
                syncLost: 1'b0,
                syncPrev: 1'b0,
                syncLive: 1'b0,
                pllLock: 1'b0,
                irqN: 1'b1,
                posPin: 1'b1,
                negPin: 1'b0,
                readData: '0,
                readValid: 1'b0
            };
        end else begin
            state <= next_state;
        end
    end

    assign irq_n = state.irqN;
    assign auxPosPinActive = state.posPin;
    assign auxNegPinActive = state.negPin;
    assign regReadData = state.readData;
    assign regReadValid = state.readValid;

endmodule

`default_nettype wire

// ---- tb/reg_bank_checker_asserts.sv ----
// Checker: port timing of the converter control and interrupt register bank.
// Assumes it is bound onto dac_ctrl_irq_status_regs and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module reg_bank_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register access
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [conv_regs_pkg::ADDR_W-1:0] regAddr,
    input wire logic [conv_regs_pkg::DATA_W-1:0] regWriteData,
    input wire logic [conv_regs_pkg::DATA_W-1:0] regReadData,
    input wire logic regReadValid,
    // Status sources
    input wire logic syncLocked,
    input wire logic pllLocked,
    input wire logic dataErrPulse,
    input wire logic syncErrPulse,
    // Converter controls
    input wire logic convSleep,
    input wire logic convPowerDown,
    input wire logic [conv_regs_pkg::GAIN_W-1:0] convGain,
    input wire logic auxNegative,
    input wire logic auxPosPinActive,
    input wire logic auxNegPinActive,
    input wire logic auxSink,
    input wire logic auxPowerDown,
    input wire logic [conv_regs_pkg::GAIN_W-1:0] auxData,
    // Interrupt pin
    input wire logic irq_n
);

default clocking @(posedge clk); endclocking
default disable iff (!reset_n);

////////////////////////////////////////////////////////////////////////////////
chk_conv_write: assert property (
    regWrite && regAddr == 5'h07 |=> {convSleep, convPowerDown, convGain}
    == {$past(regWriteData[15:14]), $past(regWriteData[9:0])})
    else $error("converter controls differ from write");
chk_aux_write: assert property (
    regWrite && regAddr == 5'h08 |=> {auxNegative, auxSink, auxPowerDown, auxData}
    == {$past(regWriteData[15:13]), $past(regWriteData[9:0])})
    else $error("aux controls differ from write");
chk_pin_pair: assert property (auxPosPinActive != auxNegPinActive)
    else $error("aux pin selects not exclusive");
chk_pin_follow: assert property (auxNegPinActive == $past(auxNegative))
    else $error("aux pin select does not follow sign");
chk_read_valid: assert property (regReadValid == $past(regRead))
    else $error("read valid timing wrong");
chk_unmapped_zero: assert property (
    regRead && !(regAddr inside {5'h07, 5'h08, 5'h09}) |=> regReadData == 16'h0000)
    else $error("unmapped read not zero");
chk_reserved_zero: assert property (
    regRead && regAddr == 5'h09 |=> (regReadData & 16'hE304) == 16'h0000)
    else $error("reserved interrupt bits not zero");
chk_live_status: assert property (
    regRead && regAddr == 5'h09 |=> regReadData[10] == $past(syncLocked, 2)
    && regReadData[3] == $past(pllLocked, 2))
    else $error("live status bits wrong");
chk_irq_cause: assert property (
    $fell(irq_n) |-> $past(dataErrPulse, 2) || $past(syncErrPulse, 2))
    else $error("interrupt pin fell without error");

endmodule

bind dac_ctrl_irq_status_regs reg_bank_checker u_chk (
    .clk(clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
    .regReadValid(regReadValid), .syncLocked(syncLocked), .pllLocked(pllLocked),
    .dataErrPulse(dataErrPulse), .syncErrPulse(syncErrPulse), .convSleep(convSleep),
    .convPowerDown(convPowerDown), .convGain(convGain), .auxNegative(auxNegative),
    .auxPosPinActive(auxPosPinActive), .auxNegPinActive(auxNegPinActive),
    .auxSink(auxSink), .auxPowerDown(auxPowerDown), .auxData(auxData), .irq_n(irq_n)
);

`default_nettype wire

// ---- tb/status_src.sv ----
// Model of the lock detectors and setup/hold checkers feeding the bank.
// Assumes the bench calls its tasks; lines change at falling clock edges.
`timescale 1ns/1ns
`default_nettype none

module status_src (
    // Clock
    input wire logic clk,
    // Status lines
    output logic syncLocked,
    output logic pllLocked,
    output logic dataErrPulse,
    output logic dataErrIsSetup,
    output logic syncErrPulse,
    output logic syncErrIsSetup
);

initial begin
    syncLocked = 1'b0;
    pllLocked = 1'b0;
    dataErrPulse = 1'b0;
    dataErrIsSetup = 1'b1;
    syncErrPulse = 1'b0;
    syncErrIsSetup = 1'b1;
end

task automatic set_lock(input logic s, input logic p);
    @(negedge clk);
    syncLocked = s;
    pllLocked = p;
endtask

// One-cycle violation; type lines show the inverse outside the pulse
task automatic pulse(input logic isData, input logic setup);
    @(negedge clk);
    dataErrPulse = isData;
    syncErrPulse = !isData;
    dataErrIsSetup = setup;
    syncErrIsSetup = setup;
    @(negedge clk);
    dataErrPulse = 1'b0;
    syncErrPulse = 1'b0;
    dataErrIsSetup = !setup;
    syncErrIsSetup = !setup;
endtask

endmodule

`default_nettype wire

// ---- tb/tb.sv ----
// Bench: register access sequences against the converter and interrupt bank.
// Assumes status_src as the status model and the bound checker.
`timescale 1ns/1ns
`default_nettype none

module tb;

logic clk = 1'b0;
logic reset_n = 1'b0;
logic regWrite = 1'b0;
logic regRead = 1'b0;
logic [4:0] regAddr = 5'h00;
logic [15:0] regWriteData = 16'h0000;
logic [15:0] regReadData, en, fl, ty;
logic regReadValid, syncLocked, pllLocked, dataErrPulse, dataErrIsSetup;
logic syncErrPulse, syncErrIsSetup, convSleep, convPowerDown, auxNegative;
logic auxPosPinActive, auxNegPinActive, auxSink, auxPowerDown, irq_n;
logic [9:0] convGain, auxData;
int nFail = 0;
int samplesChecked = 0;

always #50 clk = ~clk;

status_src src (.clk(clk), .syncLocked(syncLocked), .pllLocked(pllLocked),
    .dataErrPulse(dataErrPulse), .dataErrIsSetup(dataErrIsSetup),
    .syncErrPulse(syncErrPulse), .syncErrIsSetup(syncErrIsSetup));

dac_ctrl_irq_status_regs DUT (.clk(clk), .reset_n(reset_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData(regReadData), .regReadValid(regReadValid), .syncLocked(syncLocked),
    .pllLocked(pllLocked), .dataErrPulse(dataErrPulse), .dataErrIsSetup(dataErrIsSetup),
    .syncErrPulse(syncErrPulse), .syncErrIsSetup(syncErrIsSetup), .convSleep(convSleep),
    .convPowerDown(convPowerDown), .convGain(convGain), .auxNegative(auxNegative),
    .auxPosPinActive(auxPosPinActive), .auxNegPinActive(auxNegPinActive),
    .auxSink(auxSink), .auxPowerDown(auxPowerDown), .auxData(auxData), .irq_n(irq_n));

////////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
        nFail++;
        $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
endtask

task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = d;
    @(negedge clk);
    regWrite = 1'b0;
endtask

task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
    check(regReadValid ? regReadData : 16'hDEAD, exp);
endtask

task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
        $display("Regression OK");
    end else begin
        $display("Regression broken");
    end
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (2000) @(posedge clk);
    nFail++;
    report_and_stop;
end

initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(5'h07, 16'h0000);
    rd(5'h08, 16'h0000);
    rd(5'h09, 16'h0000);
    check({15'h0, irq_n}, 16'h0001);
    wr(5'h07, 16'hFFFF);
    rd(5'h07, 16'hC3FF);
    check({convSleep, convPowerDown, 4'h0, convGain}, 16'hC3FF);
    wr(5'h08, 16'hFFFF);
    rd(5'h08, 16'hE3FF);
    check({auxNegPinActive, auxPosPinActive, auxSink, auxPowerDown, 2'b0, auxData},
        16'hB3FF);
    wr(5'h08, 16'h0155);
    rd(5'h08, 16'h0155);
    check({auxNegPinActive, auxPosPinActive, auxSink, auxPowerDown, 2'b0, auxData},
        16'h4155);
    wr(5'h0A, 16'hFFFF);
    rd(5'h0A, 16'h0000);
    wr(5'h09, 16'hFFFF);
    rd(5'h09, 16'h1003);
    wr(5'h09, 16'h0000);
    src.set_lock(1'b1, 1'b1);
    rd(5'h09, 16'h0408);
    src.set_lock(1'b0, 1'b1);
    rd(5'h09, 16'h0808);
    src.set_lock(1'b1, 1'b1);
    rd(5'h09, 16'h0C08);
    wr(5'h09, 16'h1000);
    rd(5'h09, 16'h1408);
    wr(5'h09, 16'h0000);
    rd(5'h09, 16'h0408);
    for (int k = 0; k < 2; k++) begin
        en = k ? 16'h0002 : 16'h0001;
        fl = k ? 16'h0080 : 16'h0040;
        ty = k ? 16'h0020 : 16'h0010;
        src.pulse(k[0], 1'b1);
        rd(5'h09, 16'h0408);
        check({15'h0, irq_n}, 16'h0001);
        wr(5'h09, en);
        src.pulse(k[0], 1'b1);
        repeat (2) @(negedge clk);
        check({15'h0, irq_n}, 16'h0000);
        rd(5'h09, 16'h0408 | en | fl | ty);
        src.pulse(k[0], 1'b0);
        rd(5'h09, 16'h0408 | en | fl);
        wr(5'h09, 16'h0000);
        repeat (2) @(negedge clk);
        check({15'h0, irq_n}, 16'h0001);
        rd(5'h09, 16'h0408);
    end
    report_and_stop;
end

endmodule

`default_nettype wire
